// file: drive_status_consts.svh
// constants of the drive status parameter bank
// assumes inclusion by the bank module and the testbench only
`ifndef DRIVE_STATUS_CONSTS_SVH
`define DRIVE_STATUS_CONSTS_SVH

// ------------------------------------------------------------
// parameter addresses on the fieldbus map
// ------------------------------------------------------------
`define ADDR_IO_PHYSICAL 16'h0802
`define ADDR_INPUT_STATUS 16'h081E
`define ADDR_OUTPUT_STATUS 16'h0820
`define ADDR_STO_INPUTS 16'h084C
`define ADDR_BRAKE_APPLY 16'h0D42
`define ADDR_BRAKE_RELEASE 16'h0D44
`define ADDR_LAST_STOP_ERR 16'h1C0A
`define ADDR_LAST_CLASS0_ERR 16'h1C12
`define ADDR_ENC_COSINE 16'h1C56
`define ADDR_IQ_ACTUAL 16'h1E02
`define ADDR_IQ_REFERENCE 16'h1E20

// ------------------------------------------------------------
// field layout and values
// ------------------------------------------------------------
`define NUM_DI 6
`define NUM_DQ 5
`define NUM_STO 2
`define IO_PHYS_DQ_LSB 8
`define WORD_ZERO 16'h0000
`define ERR_CLASS_WARN 3'h0
`define ERR_CLASS_STOP_MIN 3'h1
`define ERR_CLASS_STOP_MAX 3'h4
`define ERR_CLASS_OVERWRITE 3'h4

`endif

// file: drive_status_pkg.sv
// types of the drive status parameter bank
// assumes the constants header is on the include path
package drive_status_pkg;

    typedef logic [15:0] word_t;
    typedef logic [2:0] err_class_t;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_IO_PHYSICAL,
        SEL_INPUT_STATUS,
        SEL_OUTPUT_STATUS,
        SEL_STO_INPUTS,
        SEL_BRAKE_APPLY,
        SEL_BRAKE_RELEASE,
        SEL_LAST_STOP_ERR,
        SEL_LAST_CLASS0_ERR,
        SEL_ENC_COSINE,
        SEL_IQ_ACTUAL,
        SEL_IQ_REFERENCE
    } reg_sel_t;

endpackage

// file: drive_status_parameter_bank.sv
// read-only status parameter bank of a servo drive on its fieldbus parameter port
// assumes digital inputs and torque-off channels are asynchronous pins,
// all other inputs come from logic on clk_i
//
// What this block does
// [R1] one word: six input levels in bits 0-5, five output levels in bits 8-12
// [R2] input status word: bits 0-5 are digital inputs zero to five
// [R3] output status word: bits 0-4 are digital outputs zero to four
// [R4] torque-off word: channel a in bit 0, channel b in bit 1
// [R5] actual torque current, signed 16 bits, 0.01 A rms steps
// [R6] reference torque current, signed 16 bits, 0.01 A rms steps
// [R7] first stopping error of classes 1-4 is latched; later ones of classes 1-3 do not replace it
// [R8] a new class-4 error always replaces the held stop error code
// [R9] latest class-0 error code is held until the next fault reset
// [R10] class-0 error word reads zero while no class-0 code is held
// [R11] brake application time, unsigned 16 bits in milliseconds
// [R12] brake release time, unsigned 16 bits in milliseconds
// [R13] encoder cosine voltage, signed 16 bits, 0.001 V steps
// [R14] fieldbus writes leave every status word unchanged
`include "drive_status_consts.svh"

module drive_status_parameter_bank
    import drive_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    // parameter port
    input wire logic [15:0] par_addr_i,
    input wire logic par_rd_i,
    input wire logic par_wr_i,
    input wire logic [15:0] par_wdata_i,
    output logic [15:0] par_rdata_o,
    output logic par_ack_o,
    output logic par_err_o,
    // pins
    input wire logic [`NUM_DI-1:0] digital_input_i,
    input wire logic [`NUM_STO-1:0] torque_off_channel_i,
    // drive logic
    input wire logic [`NUM_DQ-1:0] digital_output_i,
    input wire logic signed [15:0] iq_actual_i,
    input wire logic signed [15:0] iq_reference_i,
    input wire logic [15:0] brake_apply_ms_i,
    input wire logic [15:0] brake_release_ms_i,
    input wire logic signed [15:0] enc_cosine_mv_i,
    input wire logic err_valid_i,
    input wire logic [2:0] err_class_i,
    input wire logic [15:0] err_code_i,
    input wire logic fault_reset_i
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [`NUM_DI-1:0] di_meta_q;
    logic [`NUM_DI-1:0] di_sync_q;
    logic [`NUM_STO-1:0] sto_meta_q;
    logic [`NUM_STO-1:0] sto_sync_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            di_meta_q <= '0;
            di_sync_q <= '0;
            sto_meta_q <= '0;
            sto_sync_q <= '0;
        end
        else
        begin
            di_meta_q <= digital_input_i;
            di_sync_q <= di_meta_q;
            sto_meta_q <= torque_off_channel_i;
            sto_sync_q <= sto_meta_q;
        end
    end

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    word_t io_physical_w;
    word_t input_status_w;
    word_t output_status_w;
    word_t sto_inputs_w;

    generate
        for (genvar b = 0; b < 16; b++)
        begin : g_bits
            assign io_physical_w[b] = (b < `NUM_DI) ? di_sync_q[b % `NUM_DI] : // [R1]
                ((b >= `IO_PHYS_DQ_LSB) && (b < `IO_PHYS_DQ_LSB + `NUM_DQ)) ?
                digital_output_i[(b + `NUM_DQ - `IO_PHYS_DQ_LSB) % `NUM_DQ] : 1'b0;
            assign input_status_w[b] = (b < `NUM_DI) ? di_sync_q[b % `NUM_DI] : 1'b0; // [R2]
            assign output_status_w[b] = (b < `NUM_DQ) ? // [R3]
                digital_output_i[b % `NUM_DQ] : 1'b0;
            assign sto_inputs_w[b] = (b < `NUM_STO) ? sto_sync_q[b % `NUM_STO] : 1'b0; // [R4]
        end
    endgenerate

    // ------------------------------------------------------------
    // error code latches
    // ------------------------------------------------------------
    word_t stop_err_q;
    word_t stop_err_d;
    logic stop_held_q;
    logic stop_held_d;
    word_t class0_err_q;
    word_t class0_err_d;

    wire err_is_stop = err_valid_i && (err_class_i >= `ERR_CLASS_STOP_MIN) &&
        (err_class_i <= `ERR_CLASS_STOP_MAX);
    wire err_is_class4 = err_valid_i && (err_class_i == `ERR_CLASS_OVERWRITE);
    wire err_is_class0 = err_valid_i && (err_class_i == `ERR_CLASS_WARN);
    wire stop_load = (err_is_stop && !stop_held_q) || err_is_class4; // [R7]

    assign stop_err_d = stop_load ? err_code_i : stop_err_q; // [R8]
    assign stop_held_d = stop_held_q || err_is_stop;
    // a class-0 event in the fault reset cycle wins over the clear
    assign class0_err_d = err_is_class0 ? err_code_i : // [R9]
        fault_reset_i ? `WORD_ZERO : class0_err_q; // [R10]

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stop_err_q <= `WORD_ZERO;
            stop_held_q <= 1'b0;
            class0_err_q <= `WORD_ZERO;
        end
        else
        begin
            stop_err_q <= stop_err_d;
            stop_held_q <= stop_held_d;
            class0_err_q <= class0_err_d;
        end
    end

    // ------------------------------------------------------------
    // parameter port decode and read
    // ------------------------------------------------------------
    reg_sel_t sel_w;
    word_t sel_word_w;

    assign sel_w = (par_addr_i == `ADDR_IO_PHYSICAL) ? SEL_IO_PHYSICAL :
        (par_addr_i == `ADDR_INPUT_STATUS) ? SEL_INPUT_STATUS :
        (par_addr_i == `ADDR_OUTPUT_STATUS) ? SEL_OUTPUT_STATUS :
        (par_addr_i == `ADDR_STO_INPUTS) ? SEL_STO_INPUTS :
        (par_addr_i == `ADDR_BRAKE_APPLY) ? SEL_BRAKE_APPLY :
        (par_addr_i == `ADDR_BRAKE_RELEASE) ? SEL_BRAKE_RELEASE :
        (par_addr_i == `ADDR_LAST_STOP_ERR) ? SEL_LAST_STOP_ERR :
        (par_addr_i == `ADDR_LAST_CLASS0_ERR) ? SEL_LAST_CLASS0_ERR :
        (par_addr_i == `ADDR_ENC_COSINE) ? SEL_ENC_COSINE :
        (par_addr_i == `ADDR_IQ_ACTUAL) ? SEL_IQ_ACTUAL :
        (par_addr_i == `ADDR_IQ_REFERENCE) ? SEL_IQ_REFERENCE : SEL_NONE;

    assign sel_word_w = (sel_w == SEL_IO_PHYSICAL) ? io_physical_w :
        (sel_w == SEL_INPUT_STATUS) ? input_status_w :
        (sel_w == SEL_OUTPUT_STATUS) ? output_status_w :
        (sel_w == SEL_STO_INPUTS) ? sto_inputs_w :
        (sel_w == SEL_BRAKE_APPLY) ? brake_apply_ms_i : // [R11]
        (sel_w == SEL_BRAKE_RELEASE) ? brake_release_ms_i : // [R12]
        (sel_w == SEL_LAST_STOP_ERR) ? stop_err_q :
        (sel_w == SEL_LAST_CLASS0_ERR) ? class0_err_q :
        (sel_w == SEL_ENC_COSINE) ? enc_cosine_mv_i : // [R13]
        (sel_w == SEL_IQ_ACTUAL) ? iq_actual_i : // [R5]
        (sel_w == SEL_IQ_REFERENCE) ? iq_reference_i : `WORD_ZERO; // [R6]

    // read wins when both strobes are high; writes store nothing
    wire rd_take = par_rd_i;
    wire wr_take = par_wr_i && !par_rd_i;
    wire rd_bad = rd_take && (sel_w == SEL_NONE);
    word_t rdata_d;
    assign rdata_d = rd_take ? sel_word_w : `WORD_ZERO;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            par_rdata_o <= `WORD_ZERO;
            par_ack_o <= 1'b0;
            par_err_o <= 1'b0;
        end
        else
        begin
            par_rdata_o <= rdata_d;
            par_ack_o <= rd_take || wr_take;
            par_err_o <= rd_bad || wr_take; // [R14]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    io_physical_read_a: assert property ( // [R1]
        par_rd_i && (par_addr_i == `ADDR_IO_PHYSICAL) |=> par_ack_o && !par_err_o &&
        par_rdata_o[`NUM_DI-1:0] == $past(di_sync_q) &&
        par_rdata_o[12:8] == $past(digital_output_i) && par_rdata_o[7:6] == 2'h0)
        else $error("physical io word wrong");

    input_status_read_a: assert property ( // [R2]
        par_rd_i && (par_addr_i == `ADDR_INPUT_STATUS) |=>
        par_rdata_o == {10'h000, $past(di_sync_q)})
        else $error("input status word wrong");

    input_sync_delay_a: assert property ( // [R2]
        par_rd_i && (par_addr_i == `ADDR_INPUT_STATUS) |=>
        par_rdata_o[`NUM_DI-1:0] == $past(digital_input_i, 3))
        else $error("input status not two stages behind pin");

    output_status_read_a: assert property ( // [R3]
        par_rd_i && (par_addr_i == `ADDR_OUTPUT_STATUS) |=>
        par_rdata_o == {11'h000, $past(digital_output_i)})
        else $error("output status word wrong");

    sto_read_a: assert property ( // [R4]
        par_rd_i && (par_addr_i == `ADDR_STO_INPUTS) |=>
        par_rdata_o == {14'h0000, $past(torque_off_channel_i, 3)})
        else $error("torque off word wrong");

    iq_actual_read_a: assert property ( // [R5]
        par_rd_i && (par_addr_i == `ADDR_IQ_ACTUAL) |=> par_rdata_o == $past(iq_actual_i))
        else $error("actual torque current wrong");

    iq_reference_read_a: assert property ( // [R6]
        par_rd_i && (par_addr_i == `ADDR_IQ_REFERENCE) |=>
        par_rdata_o == $past(iq_reference_i))
        else $error("reference torque current wrong");

    stop_err_sticky_a: assert property ( // [R7]
        stop_held_q && !err_is_class4 |=> $stable(stop_err_q))
        else $error("held stop error replaced");

    stop_err_first_a: assert property ( // [R7]
        !stop_held_q && err_is_stop ##1 par_rd_i && (par_addr_i == `ADDR_LAST_STOP_ERR)
        |=> par_rdata_o == $past(err_code_i, 2))
        else $error("first stop error not latched");

    class4_overwrite_a: assert property ( // [R8]
        err_is_class4 |=> stop_err_q == $past(err_code_i) && stop_held_q)
        else $error("class 4 error did not replace code");

    class0_hold_a: assert property ( // [R9]
        err_is_class0 ##1 (!err_is_class0 && !fault_reset_i)[*2] |=>
        class0_err_q == $past(err_code_i, 3))
        else $error("class 0 code not held");

    class0_clear_a: assert property ( // [R10]
        fault_reset_i && !err_is_class0 ##1 par_rd_i &&
        (par_addr_i == `ADDR_LAST_CLASS0_ERR) && !err_is_class0 |=> par_rdata_o == 16'h0000)
        else $error("class 0 word not zero after fault reset");

    brake_times_read_a: assert property ( // [R11]
        par_rd_i && (par_addr_i == `ADDR_BRAKE_APPLY) |=>
        par_rdata_o == $past(brake_apply_ms_i))
        else $error("brake apply time wrong");

    brake_release_read_a: assert property ( // [R12]
        par_rd_i && (par_addr_i == `ADDR_BRAKE_RELEASE) |=>
        par_rdata_o == $past(brake_release_ms_i))
        else $error("brake release time wrong");

    cosine_read_a: assert property ( // [R13]
        par_rd_i && (par_addr_i == `ADDR_ENC_COSINE) |=>
        par_rdata_o == $past(enc_cosine_mv_i))
        else $error("cosine voltage wrong");

    write_ignored_a: assert property ( // [R14]
        par_wr_i && !par_rd_i && !err_valid_i && !fault_reset_i |=>
        par_ack_o && par_err_o && $stable(stop_err_q) && $stable(class0_err_q))
        else $error("write changed a status word");

endmodule

// file: fieldbus_master_model.sv
// fieldbus master that issues parameter reads and writes to the status bank
// assumes one request per clock, driven just after the rising edge of clk_i
module fieldbus_master_model (
    input wire logic clk_i,
    output logic [15:0] par_addr_o,
    output logic par_rd_o,
    output logic par_wr_o,
    output logic [15:0] par_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // request drivers
    // ----------------------------------------------------------
    initial
    begin
        par_addr_o = 16'h0000;
        par_rd_o = 1'b0;
        par_wr_o = 1'b0;
        par_wdata_o = 16'h0000;
    end

    // one request, held until the next access or idle call
    task automatic access(input logic rd, input logic wr, input logic [15:0] addr,
                          input logic [15:0] data);
        @(posedge clk_i);
        par_rd_o <= rd;
        par_wr_o <= wr;
        par_addr_o <= addr;
        par_wdata_o <= data;
    endtask

    // strobes drop; address and data lines show the inverse of their last value
    task automatic idle();
        @(posedge clk_i);
        par_rd_o <= 1'b0;
        par_wr_o <= 1'b0;
        par_addr_o <= ~par_addr_o;
        par_wdata_o <= ~par_wdata_o;
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the drive status parameter bank
// assumes the bank, its package and constants header, and the master model
`include "drive_status_consts.svh"

module tb_top
    import drive_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------
    logic clk_i, arst_n_i, par_rd, par_wr, par_ack, par_err, ev_v, fr;
    logic [15:0] par_addr, par_wdata, par_rdata;
    logic [5:0] di;
    logic [1:0] sto;
    logic [4:0] dq;
    word_t iq_a, iq_r, bk_a, bk_r, cosv, ev_code, stop_m, warn_m;
    err_class_t ev_c;
    word_t addr_tab [11];
    logic [16:0] exp_q [$];
    logic [31:0] r0, r1;
    int num_errors, checks, seed;

    drive_status_parameter_bank drive_status_parameter_bank_i (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .par_addr_i(par_addr), .par_rd_i(par_rd), .par_wr_i(par_wr),
        .par_wdata_i(par_wdata), .par_rdata_o(par_rdata), .par_ack_o(par_ack),
        .par_err_o(par_err), .digital_input_i(di), .torque_off_channel_i(sto),
        .digital_output_i(dq), .iq_actual_i(iq_a), .iq_reference_i(iq_r),
        .brake_apply_ms_i(bk_a), .brake_release_ms_i(bk_r), .enc_cosine_mv_i(cosv),
        .err_valid_i(ev_v), .err_class_i(ev_c), .err_code_i(ev_code), .fault_reset_i(fr));
    fieldbus_master_model fieldbus_master_model_i (.clk_i(clk_i), .par_addr_o(par_addr),
        .par_rd_o(par_rd), .par_wr_o(par_wr), .par_wdata_o(par_wdata));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic word_t exp_word(input int k);
        case (k)
            0: return {3'h0, dq, 2'h0, di};
            1: return {10'h000, di};
            2: return {11'h000, dq};
            3: return {14'h0000, sto};
            4: return bk_a;
            5: return bk_r;
            6: return stop_m;
            7: return warn_m;
            8: return cosv;
            9: return iq_a;
            default: return iq_r;
        endcase
    endfunction

    task automatic chk(input logic [16:0] seen, input logic [16:0] expd);
        checks++;
        if (seen !== expd)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic read_all();
        for (int k = 0; k < 11; k++)
        begin
            exp_q.push_back({1'b0, exp_word(k)});
            fieldbus_master_model_i.access(1'b1, 1'b0, addr_tab[k], 16'h0000);
        end
        fieldbus_master_model_i.idle();
    endtask

    task automatic new_inputs();
        @(posedge clk_i);
        r0 = $random(seed);
        r1 = $random(seed);
        di <= r0[5:0];
        sto <= r0[7:6];
        dq <= r0[12:8];
        iq_a <= r0[31:16];
        iq_r <= r1[15:0];
        bk_a <= r1[31:16];
        r0 = $random(seed);
        bk_r <= r0[15:0];
        cosv <= r0[31:16];
        repeat (4) @(posedge clk_i);
    endtask

    task automatic err_event(input logic v, input err_class_t c, input word_t code,
                             input logic rst);
        @(posedge clk_i);
        ev_v <= v;
        ev_c <= c;
        ev_code <= code;
        fr <= rst;
        @(posedge clk_i);
        ev_v <= 1'b0;
        fr <= 1'b0;
        ev_code <= ~code;
        if (rst)
            warn_m = 16'h0000;
        if (v && c == 3'h0)
            warn_m = code;
        else if (v && c == 3'h4)
            stop_m = code;
        else if (v && c < 3'h4 && stop_m == 16'h0000)
            stop_m = code;
        read_all();
    endtask

    // ----------------------------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        if (par_ack === 1'b1)
            chk({par_err, par_rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF);
        else
            chk({par_err, par_rdata}, 17'h00000);
    end

    initial
    begin
        #100000;
        num_errors++;
        end_sim();
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        seed = 32'h666E;
        {arst_n_i, ev_v, fr, ev_c, di, sto, dq} = '0;
        {iq_a, iq_r, bk_a, bk_r, cosv, ev_code, stop_m, warn_m} = '0;
        addr_tab = '{`ADDR_IO_PHYSICAL, `ADDR_INPUT_STATUS, `ADDR_OUTPUT_STATUS,
            `ADDR_STO_INPUTS, `ADDR_BRAKE_APPLY, `ADDR_BRAKE_RELEASE, `ADDR_LAST_STOP_ERR,
            `ADDR_LAST_CLASS0_ERR, `ADDR_ENC_COSINE, `ADDR_IQ_ACTUAL, `ADDR_IQ_REFERENCE};
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        read_all();
        repeat (12)
        begin
            new_inputs();
            read_all();
        end
        for (int k = 0; k < 11; k++)
        begin
            exp_q.push_back({1'b1, 16'h0000});
            fieldbus_master_model_i.access(1'b0, 1'b1, addr_tab[k], 16'hA5C3 ^ k[15:0]);
        end
        exp_q.push_back({1'b1, 16'h0000});
        fieldbus_master_model_i.access(1'b1, 1'b0, 16'h0803, 16'h0000);
        fieldbus_master_model_i.idle();
        read_all();
        err_event(1'b1, 3'h0, 16'h0101, 1'b0);
        err_event(1'b1, 3'h2, 16'h0202, 1'b0);
        err_event(1'b1, 3'h3, 16'h0303, 1'b0);
        err_event(1'b1, 3'h5, 16'h0505, 1'b0);
        err_event(1'b1, 3'h4, 16'h0404, 1'b0);
        err_event(1'b1, 3'h1, 16'h0111, 1'b0);
        err_event(1'b1, 3'h4, 16'h0444, 1'b0);
        err_event(1'b0, 3'h0, 16'h0000, 1'b1);
        err_event(1'b1, 3'h0, 16'h0A0A, 1'b1);
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule
